// ---- logic/range_compare_defines.svh ----
// constants for the range-compare flag unit
`ifndef RANGE_COMPARE_DEFINES_SVH
`define RANGE_COMPARE_DEFINES_SVH

// =====================================================================
// function codes
`define RC_OP_SINGLE 8'h58
`define RC_OP_DOUBLE 8'h74

// =====================================================================
// widths
`define RC_WORD_W 16
`define RC_DWORD_W 32
`define RC_OP_W 8
`define RC_FLAG_W 8

// =====================================================================
// flag bit positions in the flag write word
`define RC_BIT_ER 0
`define RC_BIT_GT 1
`define RC_BIT_EQ 2
`define RC_BIT_LT 3
`define RC_BIT_GE 4
`define RC_BIT_NE 5
`define RC_BIT_LE 6
`define RC_BIT_N 7

// =====================================================================
// reset value and zero-extension word
`define RC_FLAG_RST 1'h0
`define RC_UPPER_ZERO 16'h0000

`endif

// ---- logic/range_compare_flag_unit.sv ----
// range-compare datapath driving the condition flags
`include "range_compare_defines.svh"

// Function
// - single form takes three 16-bit words
// - double form: higher-address word is upper half
// - error flag when lower exceeds upper limit
// - greater flag alone when value exceeds upper and lower does not exceed upper
// - equals flag when value within inclusive range
// - less flag alone when value below lower and lower does not exceed upper
// - other four flags keep previous values
module range_compare_flag_unit
  import range_compare_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // instruction request from the sequencer
  input wire logic exec_i,
  input wire logic [`RC_OP_W-1:0] opcode_i,
  // operand words, lo at the lower address
  input wire word_t comparison_value_lo_i,
  input wire word_t comparison_value_hi_i,
  input wire word_t lower_limit_lo_i,
  input wire word_t lower_limit_hi_i,
  input wire word_t upper_limit_lo_i,
  input wire word_t upper_limit_hi_i,
  // flag load by other instructions
  input wire logic flag_wr_i,
  input wire logic [`RC_FLAG_W-1:0] flag_wdata_i,
  // completion
  output logic done_o,
  // condition flags
  output logic error_flag_o,
  output logic greater_than_flag_o,
  output logic equals_flag_o,
  output logic less_than_flag_o,
  output logic greater_or_equal_flag_o,
  output logic not_equal_flag_o,
  output logic less_or_equal_flag_o,
  output logic negative_flag_o
);

  // =====================================================================
  // opcode decode
  function automatic op_kind_t decode_op(input logic [`RC_OP_W-1:0] code);
    op_kind_t kind;
    kind = OP_NONE;
    if (code == `RC_OP_SINGLE)
      kind = OP_SINGLE;
    else if (code == `RC_OP_DOUBLE)
      kind = OP_DOUBLE;
    return kind;
  endfunction

  op_kind_t op_kind;
  logic run;
  logic is_double;
  word_t lo_words [3];
  word_t hi_words [3];
  dword_t operands [3];
  logic cmp_gt;
  logic cmp_eq;
  logic cmp_lt;
  logic cmp_err;

  assign op_kind = decode_op(opcode_i);
  assign run = exec_i && (op_kind != OP_NONE);
  assign is_double = (decode_op(opcode_i) == OP_DOUBLE);

  assign lo_words[0] = comparison_value_lo_i;
  assign lo_words[1] = lower_limit_lo_i;
  assign lo_words[2] = upper_limit_lo_i;
  assign hi_words[0] = comparison_value_hi_i;
  assign hi_words[1] = lower_limit_hi_i;
  assign hi_words[2] = upper_limit_hi_i;

  // =====================================================================
  // operand assembly
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_operand
      // single form zero-extends one word, double form joins two
      assign operands[gi] = is_double ? {hi_words[gi], lo_words[gi]}
                                      : {`RC_UPPER_ZERO, lo_words[gi]};
    end
  endgenerate

  // =====================================================================
  // comparator
  range_window_cmp u_cmp
  (
    .value_i(operands[0]),
    .low_i(operands[1]),
    .high_i(operands[2]),
    .gt_o(cmp_gt),
    .eq_o(cmp_eq),
    .lt_o(cmp_lt),
    .err_o(cmp_err)
  );

  // =====================================================================
  // result flags written by the range compare
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      error_flag_o <= `RC_FLAG_RST;
      greater_than_flag_o <= `RC_FLAG_RST;
      equals_flag_o <= `RC_FLAG_RST;
      less_than_flag_o <= `RC_FLAG_RST;
    end
    else if (run)
    begin
      error_flag_o <= cmp_err;
      greater_than_flag_o <= cmp_gt;
      equals_flag_o <= cmp_eq;
      less_than_flag_o <= cmp_lt;
    end
    else if (flag_wr_i)
    begin
      error_flag_o <= flag_wdata_i[`RC_BIT_ER];
      greater_than_flag_o <= flag_wdata_i[`RC_BIT_GT];
      equals_flag_o <= flag_wdata_i[`RC_BIT_EQ];
      less_than_flag_o <= flag_wdata_i[`RC_BIT_LT];
    end
  end

  // =====================================================================
  // flags the range compare never touches
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      greater_or_equal_flag_o <= `RC_FLAG_RST;
      not_equal_flag_o <= `RC_FLAG_RST;
      less_or_equal_flag_o <= `RC_FLAG_RST;
      negative_flag_o <= `RC_FLAG_RST;
    end
    // a range compare in the same cycle blocks the load
    else if (flag_wr_i && !run)
    begin
      greater_or_equal_flag_o <= flag_wdata_i[`RC_BIT_GE];
      not_equal_flag_o <= flag_wdata_i[`RC_BIT_NE];
      less_or_equal_flag_o <= flag_wdata_i[`RC_BIT_LE];
      negative_flag_o <= flag_wdata_i[`RC_BIT_N];
    end
  end

  // =====================================================================
  // completion pulse, flags valid with it
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      done_o <= `RC_FLAG_RST;
    else
      done_o <= run;
  end

  // =====================================================================
  // checks
  property p_single_gt;
    @(posedge clock_i) disable iff (sys_rst_i)
    (exec_i && opcode_i == `RC_OP_SINGLE)
      |=> greater_than_flag_o == ($past(comparison_value_lo_i) > $past(upper_limit_lo_i));
  endproperty
  a_single_gt: assert property (p_single_gt)
    else $error("greater flag wrong after single compare");

  property p_single_lt;
    @(posedge clock_i) disable iff (sys_rst_i)
    (exec_i && opcode_i == `RC_OP_SINGLE)
      |=> less_than_flag_o == ($past(comparison_value_lo_i) < $past(lower_limit_lo_i));
  endproperty
  a_single_lt: assert property (p_single_lt)
    else $error("less flag wrong after single compare");

  property p_single_eq;
    @(posedge clock_i) disable iff (sys_rst_i)
    (exec_i && opcode_i == `RC_OP_SINGLE)
      |=> equals_flag_o == (($past(comparison_value_lo_i) >= $past(lower_limit_lo_i))
                            && ($past(comparison_value_lo_i) <= $past(upper_limit_lo_i)));
  endproperty
  a_single_eq: assert property (p_single_eq)
    else $error("equals flag wrong after single compare");

  property p_double_gt;
    @(posedge clock_i) disable iff (sys_rst_i)
    (exec_i && opcode_i == `RC_OP_DOUBLE)
      |=> greater_than_flag_o ==
          ({$past(comparison_value_hi_i), $past(comparison_value_lo_i)}
           > {$past(upper_limit_hi_i), $past(upper_limit_lo_i)});
  endproperty
  a_double_gt: assert property (p_double_gt)
    else $error("greater flag wrong after double compare");

  property p_double_err;
    @(posedge clock_i) disable iff (sys_rst_i)
    (exec_i && opcode_i == `RC_OP_DOUBLE)
      |=> error_flag_o ==
          ({$past(lower_limit_hi_i), $past(lower_limit_lo_i)}
           > {$past(upper_limit_hi_i), $past(upper_limit_lo_i)});
  endproperty
  a_double_err: assert property (p_double_err)
    else $error("error flag wrong after double compare");

  property p_single_err;
    @(posedge clock_i) disable iff (sys_rst_i)
    (exec_i && opcode_i == `RC_OP_SINGLE && lower_limit_lo_i > upper_limit_lo_i)
      |=> error_flag_o && !equals_flag_o;
  endproperty
  a_single_err: assert property (p_single_err)
    else $error("error flag missing after inverted limits");

  property p_exclusive;
    @(posedge clock_i) disable iff (sys_rst_i)
    (run && !cmp_err) |=> ($countones({greater_than_flag_o, equals_flag_o,
                                       less_than_flag_o}) == 1) && done_o;
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("result flags not exclusive after compare");

  property p_hold_others;
    @(posedge clock_i) disable iff (sys_rst_i)
    run |=> $stable(greater_or_equal_flag_o) && $stable(not_equal_flag_o)
            && $stable(less_or_equal_flag_o) && $stable(negative_flag_o);
  endproperty
  a_hold_others: assert property (p_hold_others)
    else $error("untouched flag changed by range compare");

  property p_unsigned;
    @(posedge clock_i) disable iff (sys_rst_i)
    (exec_i && opcode_i == `RC_OP_SINGLE && comparison_value_lo_i[`RC_WORD_W-1]
     && !upper_limit_lo_i[`RC_WORD_W-1]) |=> greater_than_flag_o;
  endproperty
  a_unsigned: assert property (p_unsigned)
    else $error("top bit treated as sign");

  property p_done_pulse;
    @(posedge clock_i) disable iff (sys_rst_i)
    !run |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done without a range compare");

endmodule

// ---- logic/range_compare_pkg.sv ----
// types shared by the range-compare flag unit
`include "range_compare_defines.svh"

package range_compare_pkg;

  typedef logic [`RC_WORD_W-1:0] word_t;
  typedef logic [`RC_DWORD_W-1:0] dword_t;

  // decoded instruction kind
  typedef enum logic [1:0]
  {
    OP_NONE = 2'b00,
    OP_SINGLE = 2'b01,
    OP_DOUBLE = 2'b11
  } op_kind_t;

endpackage

// ---- logic/range_window_cmp.sv ----
// unsigned window comparator for the range-compare flag unit
module range_window_cmp
  import range_compare_pkg::*;
(
  // operands
  input wire dword_t value_i,
  input wire dword_t low_i,
  input wire dword_t high_i,
  // results
  output logic gt_o,
  output logic eq_o,
  output logic lt_o,
  output logic err_o
);

  // =====================================================================
  // magnitude compare
  always_comb
  begin
    gt_o = (value_i > high_i);
    lt_o = (value_i < low_i);
    eq_o = (value_i >= low_i) && (value_i <= high_i);
    err_o = (low_i > high_i);
  end

endmodule

// ---- sim/instr_seq_model.sv ----
// instruction sequencer model that issues range compares
module instr_seq_model
  import range_compare_pkg::*;
(
  // clock
  input wire logic clock_i,
  // request to the flag unit
  output logic exec_o,
  output logic [7:0] opcode_o,
  output dword_t cv_o,
  output dword_t ll_o,
  output dword_t ul_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================================================
  // idle state
  initial
  begin
    exec_o = 1'b0;
    opcode_o = 8'h00;
    cv_o = 32'h0;
    ll_o = 32'h0;
    ul_o = 32'h0;
  end

  // =====================================================================
  // one instruction, called just after a falling edge
  task automatic issue(input logic [7:0] op, input dword_t cv, input dword_t ll,
                       input dword_t ul);
    exec_o = 1'b1;
    opcode_o = op;
    cv_o = cv;
    ll_o = ll;
    ul_o = ul;
    @(negedge clock_i);
    // released operands flip so stale values never look valid
    exec_o = 1'b0;
    cv_o = ~cv;
    ll_o = ~ll;
    ul_o = ~ul;
    // caller reads the flags now, with no instruction between
    opcode_o = ~op;
  endtask
endmodule

// ---- sim/test_range_compare_flag_unit.sv ----
// self-checking bench for the range-compare flag unit
`include "range_compare_defines.svh"
module test_range_compare_flag_unit
  import range_compare_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // res holds {lt, eq, gt, err}
  typedef struct packed {
    logic [7:0] op;
    dword_t cv;
    dword_t ll;
    dword_t ul;
    logic [3:0] res;
  } row_t;

  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic flag_wr_i = 1'b0;
  logic [7:0] flag_wdata_i = 8'h00;
  logic exec_i;
  logic [7:0] opcode_i;
  dword_t cv;
  dword_t ll;
  dword_t ul;
  logic done_o;
  wire logic [7:0] flags;
  int n_fail = 0;
  int comparisons = 0;
  row_t rows [12] = '{
    {8'h58, 32'h3, 32'h5, 32'h1f, 4'h8}, {8'h58, 32'h5, 32'h5, 32'h1f, 4'h4},
    {8'h58, 32'h1f, 32'h5, 32'h1f, 4'h4}, {8'h58, 32'h20, 32'h5, 32'h1f, 4'h2},
    {8'h58, 32'hffff_0010, 32'hffff_0005, 32'h1f, 4'h4},
    {8'h58, 32'h8000, 32'h5, 32'h1f, 4'h2}, {8'h58, 32'h7, 32'ha, 32'h5, 4'hb},
    {8'h74, 32'h1_0000, 32'h5, 32'hffff, 4'h2},
    {8'h74, 32'hffff, 32'h1_0000, 32'h2_0000, 4'h8},
    {8'h74, 32'h8000_0000, 32'h1, 32'hffff_ffff, 4'h4},
    {8'h74, 32'h3_0000, 32'h3_0000, 32'h2_ffff, 4'h3},
    {8'h58, 32'h1234, 32'h1234, 32'h1234, 4'h4}};

  always #5 clock_i = ~clock_i;

  instr_seq_model u_seq (.clock_i(clock_i), .exec_o(exec_i), .opcode_o(opcode_i),
                         .cv_o(cv), .ll_o(ll), .ul_o(ul));

  range_compare_flag_unit u_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .exec_i(exec_i), .opcode_i(opcode_i),
    .comparison_value_lo_i(cv[15:0]), .comparison_value_hi_i(cv[31:16]),
    .lower_limit_lo_i(ll[15:0]), .lower_limit_hi_i(ll[31:16]),
    .upper_limit_lo_i(ul[15:0]), .upper_limit_hi_i(ul[31:16]),
    .flag_wr_i(flag_wr_i), .flag_wdata_i(flag_wdata_i), .done_o(done_o),
    .error_flag_o(flags[0]), .greater_than_flag_o(flags[1]), .equals_flag_o(flags[2]),
    .less_than_flag_o(flags[3]), .greater_or_equal_flag_o(flags[4]),
    .not_equal_flag_o(flags[5]), .less_or_equal_flag_o(flags[6]),
    .negative_flag_o(flags[7]));

  // =====================================================================
  // compare and verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // =====================================================================
  // watchdog
  initial
  begin
    repeat (500) @(posedge clock_i);
    n_fail++;
    tally_and_finish();
  end

  // =====================================================================
  // main sequence
  initial
  begin
    logic [3:0] pre;
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'b0;
    chk("reset flags", 8'h00, flags);
    chk("reset done", 8'h00, {7'h0, done_o});
    for (int i = 0; i < 12; i++)
    begin
      pre = (i % 2 == 1) ? 4'h5 : 4'ha;
      flag_wr_i = 1'b1;
      flag_wdata_i = {pre, ~rows[i].res};
      @(negedge clock_i);
      flag_wr_i = 1'b0;
      u_seq.issue(rows[i].op, rows[i].cv, rows[i].ll, rows[i].ul);
      chk("done", 8'h01, {7'h0, done_o});
      chk("flags", {pre, rows[i].res}, flags);
      chk("kept flags", {pre, 4'h0}, flags & 8'hf0);
    end
    // flag load in the same edge as a compare is dropped
    @(negedge clock_i);
    flag_wr_i = 1'b1;
    flag_wdata_i = 8'hff;
    u_seq.issue(8'h58, 32'h9, 32'h5, 32'h1f);
    flag_wr_i = 1'b0;
    chk("collide", 8'h54, flags);
    // unknown opcode changes nothing
    @(negedge clock_i);
    u_seq.issue(8'h00, 32'h0, 32'h5, 32'h1f);
    chk("refused done", 8'h00, {7'h0, done_o});
    chk("refused flags", 8'h54, flags);
    // plain load reaches all eight flags
    flag_wr_i = 1'b1;
    flag_wdata_i = 8'h3c;
    @(negedge clock_i);
    flag_wr_i = 1'b0;
    chk("flag load", 8'h3c, flags);
    sys_rst_i = 1'b1;
    @(negedge clock_i);
    chk("midrun reset", 8'h00, flags);
    chk("midrun reset done", 8'h00, {7'h0, done_o});
    // a compare right after a second release
    sys_rst_i = 1'b0;
    u_seq.issue(8'h74, 32'h2_0000, 32'h1_0000, 32'h3_0000);
    chk("after reset done", 8'h01, {7'h0, done_o});
    chk("after reset flags", 8'h04, flags);
    tally_and_finish();
  end
endmodule
